// file: rtl/dacsp_pkg.sv
// package for the two-wire slave port: addresses, codes, bit counts
// assumes a single system clock; imported by the port, which sizes its fifo from it
package dacsp_pkg;
  // fixed upper four address bits
  localparam logic [3:0] DACSP_ADDR_PREFIX = 4'h9;
  // broadcast address, write only
  localparam logic [6:0] DACSP_BCAST_ADDR = 7'h47;
  // lower address bits per address-select strap
  localparam logic [2:0] DACSP_SEL_GND = 3'h0;
  localparam logic [2:0] DACSP_SEL_VDD = 3'h1;
  localparam logic [2:0] DACSP_SEL_SDA = 3'h2;
  localparam logic [2:0] DACSP_SEL_SCL = 3'h3;
  // address-select pin states as sensed by the pad
  localparam logic [1:0] DACSP_PIN_GND = 2'h0;
  localparam logic [1:0] DACSP_PIN_VDD = 2'h1;
  localparam logic [1:0] DACSP_PIN_SDA = 2'h2;
  localparam logic [1:0] DACSP_PIN_SCL = 2'h3;
  // general call address and reset code
  localparam logic [7:0] DACSP_GCALL_ADDR = 8'h00;
  localparam logic [7:0] DACSP_GCALL_RESET = 8'h06;
  // 10-bit addressing prefix, top five bits 11110
  localparam logic [4:0] DACSP_TEN_BIT_PREFIX = 5'h1E;
  // bits per data unit before the acknowledge clock
  localparam logic [3:0] DACSP_BITS_PER_BYTE = 4'h8;
  // fifo geometry: one word is command plus two data bytes
  localparam int DACSP_FIFO_WIDTH = 24;
  localparam int DACSP_FIFO_DEPTH = 8;
  // byte phases of a frame
  typedef enum logic [2:0]
  {
    DACSP_IDLE = 3'b000,
    DACSP_ADDR = 3'b001,
    DACSP_CMD = 3'b011,
    DACSP_HIGH = 3'b010,
    DACSP_LOW = 3'b110,
    DACSP_READ = 3'b111,
    DACSP_GCALL = 3'b101,
    DACSP_IGNORE = 3'b100
  } dacsp_state_e;
endpackage : dacsp_pkg

// file: rtl/dacsp_fifo.sv
// small synchronous fifo with valid and ready on both sides
// assumes one clock, asynchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module dacsp_fifo
#(
  parameter int WIDTH = 24,
  parameter int DEPTH = 8
)
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  // storage words
  logic [WIDTH-1:0] mem [DEPTH];
  // pointers with wrap bit
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic push;
  logic pop;
  // full when pointers differ only in wrap bit
  assign in_ready = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
  assign out_valid = (wr_ptr != rd_ptr);
  assign out_data = mem[rd_ptr[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  // write side
  always_ff @(posedge clock)
  begin
    if (push)
    begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end
  // pointer update
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop)
      begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule : dacsp_fifo
`default_nettype wire

// file: rtl/dacsp_port.sv
// two-wire serial slave port: address match, write and read frames
// assumes scl and sda arrive asynchronously; pads resolve open drain
// What this block does
// - only 7-bit addresses; 10-bit never acknowledged
// - general call 00 then 06 resets
// - reset pulses at ack rise after second byte
// - ninth clock carries acknowledge, low means ack
// - detect start: sda falls while scl high
// - stop releases bus, await start and address
// - sda changes only while scl low
// - acknowledge address on own match, broadcast write or general call
// - eight bits plus ack, receiver acknowledges
// - direction bit picks write or read
// - update is address, command, upper, lower bytes
// - update applied at falling edge after lower ack
// - address prefix fixed at 1001
// - strap gnd 000, vdd 001, sda 010
// - strap sampled in first byte, latched
// - broadcast 1000111 acknowledged for writes only
// - lines open drain, only pull low
// - same protocol at every bit rate
// - read returns upper then lower byte
// - bare read returns last written register
// - command byte names target register
`timescale 1ns/1ps
`default_nettype none
module dacsp_port
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [1:0] address_select_pin,
  output logic soft_reset,
  output logic wr_valid,
  input wire logic wr_ready,
  output logic [7:0] wr_command,
  output logic [7:0] upper_data_byte,
  output logic [7:0] lower_data_byte,
  output logic [7:0] rd_command,
  input wire logic [15:0] rd_data
);
  import dacsp_pkg::*;

  // synchronisers, two flops each
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic [1:0] sel_sync0;
  logic [1:0] sel_sync1;
  // previous synchronised levels for edge detection
  logic scl_d;
  logic sda_d;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  // frame state
  dacsp_state_e state;
  logic [3:0] bit_cnt; // 0..7 data, 8 ack clock
  logic [7:0] shift;
  logic ack_phase; // inside the ninth clock
  logic ack_drive; // we acknowledge this byte
  logic rd_drive_ok; // master acked, keep sending
  logic [2:0] sel_latch; // latched lower address bits
  logic [7:0] cmd_reg;
  logic [7:0] hi_reg;
  logic [7:0] lo_reg;
  logic [7:0] last_cmd; // last written register
  logic [15:0] tx_word;
  logic rd_second; // sending lower byte
  logic gcall_pend; // reset code seen, pulse at ack rise
  logic update_pend; // lower byte acked, await fall
  logic cmd_sel; // command byte given, read picks it
  logic [DACSP_FIFO_WIDTH-1:0] fifo_in;
  logic fifo_ready;
  logic [DACSP_FIFO_WIDTH-1:0] fifo_out;
  logic fifo_valid;
  logic [6:0] own_addr;

  // synchronise pins before use
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      sel_sync0 <= 2'h0;
      sel_sync1 <= 2'h0;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end
    else
    begin
      scl_sync <= {scl_sync[0], scl_in};
      sda_sync <= {sda_sync[0], sda_in};
      sel_sync0 <= address_select_pin;
      sel_sync1 <= sel_sync0;
      scl_d <= scl_sync[1];
      sda_d <= sda_sync[1];
    end
  end

  // edges of the bus lines; rate independent sampling
  assign scl_rise = scl_sync[1] && !scl_d;
  assign scl_fall = !scl_sync[1] && scl_d;
  assign start_cond = scl_sync[1] && scl_d && sda_d && !sda_sync[1];
  assign stop_cond = scl_sync[1] && scl_d && !sda_d && sda_sync[1];
  // own address from prefix and latched strap
  assign own_addr = {DACSP_ADDR_PREFIX, sel_latch};

  // strap decode, latched while the first byte shifts
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sel_latch <= DACSP_SEL_GND;
    end
    else if (state == DACSP_ADDR && !ack_phase && scl_rise)
    begin
      case (sel_sync1)
        DACSP_PIN_GND: sel_latch <= DACSP_SEL_GND;
        DACSP_PIN_VDD: sel_latch <= DACSP_SEL_VDD;
        DACSP_PIN_SDA: sel_latch <= DACSP_SEL_SDA;
        default: sel_latch <= DACSP_SEL_SCL;
      endcase
    end
  end

  // bit counter on scl fall, shift register sampled on scl rise
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      ack_phase <= 1'b0;
    end
    else if (start_cond)
    begin
      // the fall that closes the start wraps this to bit 0
      bit_cnt <= '1;
      ack_phase <= 1'b0;
    end
    else if (scl_rise)
    begin
      shift <= {shift[6:0], sda_sync[1]};
    end
    else if (scl_fall && state != DACSP_IDLE)
    begin
      // count clocks: eight data then the ack clock
      if (bit_cnt == DACSP_BITS_PER_BYTE)
      begin
        bit_cnt <= 4'h0;
        ack_phase <= 1'b0;
      end
      else
      begin
        bit_cnt <= bit_cnt + 4'h1;
        ack_phase <= (bit_cnt == DACSP_BITS_PER_BYTE - 4'h1);
      end
    end
  end

  // frame state machine, advances after each eighth bit
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state <= DACSP_IDLE;
      ack_drive <= 1'b0;
      cmd_reg <= 8'h00;
      hi_reg <= 8'h00;
      rd_second <= 1'b0;
      gcall_pend <= 1'b0;
      update_pend <= 1'b0;
      rd_drive_ok <= 1'b0;
    end
    else if (start_cond)
    begin
      state <= DACSP_ADDR;
      ack_drive <= 1'b0;
      gcall_pend <= 1'b0;
      update_pend <= 1'b0;
    end
    else if (stop_cond)
    begin
      state <= DACSP_IDLE;
      ack_drive <= 1'b0;
      gcall_pend <= 1'b0;
    end
    else if (scl_fall && bit_cnt == DACSP_BITS_PER_BYTE - 4'h1 && !ack_phase)
    begin
      // byte complete: decide acknowledge and next phase
      ack_drive <= 1'b0;
      case (state)
        DACSP_ADDR:
        begin
          if (shift[7:3] == DACSP_TEN_BIT_PREFIX)
          begin
            state <= DACSP_IGNORE;
          end
          else if (shift == DACSP_GCALL_ADDR)
          begin
            state <= DACSP_GCALL;
            ack_drive <= 1'b1;
          end
          else if (shift[7:1] == own_addr)
          begin
            ack_drive <= 1'b1;
            state <= shift[0] ? DACSP_READ : DACSP_CMD;
            rd_second <= 1'b0;
            rd_drive_ok <= 1'b1;
          end
          else if (shift[7:1] == DACSP_BCAST_ADDR && !shift[0])
          begin
            ack_drive <= 1'b1;
            state <= DACSP_CMD;
          end
          else
          begin
            state <= DACSP_IGNORE;
          end
        end
        DACSP_GCALL:
        begin
          ack_drive <= (shift == DACSP_GCALL_RESET);
          gcall_pend <= (shift == DACSP_GCALL_RESET);
          state <= DACSP_IGNORE;
        end
        DACSP_CMD:
        begin
          cmd_reg <= shift;
          ack_drive <= 1'b1;
          state <= DACSP_HIGH;
        end
        DACSP_HIGH:
        begin
          hi_reg <= shift;
          ack_drive <= 1'b1;
          state <= DACSP_LOW;
        end
        DACSP_LOW:
        begin
          // refuse the byte when the write queue is full
          ack_drive <= fifo_ready;
          update_pend <= fifo_ready;
          state <= DACSP_HIGH;
        end
        default:
        begin
          state <= state;
        end
      endcase
    end
    else if (scl_rise && ack_phase && state == DACSP_READ && !ack_drive)
    begin
      // our own address ack is not an answer from the master
      // master ack after the upper byte keeps us transmitting, nack ends it
      rd_drive_ok <= !sda_sync[1] && !rd_second;
      rd_second <= 1'b1;
    end
    else if (scl_fall && ack_phase)
    begin
      update_pend <= 1'b0;
    end
  end

  // lower byte register and last written command
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      lo_reg <= 8'h00;
      last_cmd <= 8'h00;
    end
    else if (scl_fall && bit_cnt == DACSP_BITS_PER_BYTE - 4'h1 && !ack_phase
             && state == DACSP_LOW && fifo_ready)
    begin
      lo_reg <= shift;
      last_cmd <= cmd_reg;
    end
  end

  // general call reset pulse at ack rise after the second byte
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      soft_reset <= 1'b0;
    end
    else
    begin
      soft_reset <= gcall_pend && ack_phase && scl_rise;
    end
  end

  // repeated start after a command byte reads that register
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cmd_sel <= 1'b0;
    end
    else if (start_cond)
    begin
      cmd_sel <= (state == DACSP_HIGH);
    end
    else if (stop_cond)
    begin
      cmd_sel <= 1'b0;
    end
  end

  // read word, loaded on the address ack for a read frame
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tx_word <= 16'h0000;
      rd_command <= 8'h00;
    end
    else
    begin
      rd_command <= cmd_sel ? cmd_reg : last_cmd;
      if (state == DACSP_READ && ack_phase && scl_rise && !rd_second)
      begin
        tx_word <= rd_data;
      end
      else if (state != DACSP_READ)
      begin
        tx_word <= rd_data;
      end
    end
  end

  // sda drive: pull low for ack or a zero data bit, else release
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sda_oe <= 1'b0;
    end
    else if (start_cond || stop_cond || state == DACSP_IDLE || state == DACSP_IGNORE
             && !ack_drive)
    begin
      sda_oe <= 1'b0;
    end
    else if (!scl_sync[1])
    begin
      if (ack_phase)
      begin
        sda_oe <= ack_drive;
      end
      else if (state == DACSP_READ && rd_drive_ok)
      begin
        sda_oe <= rd_second ? !tx_word[4'h7 - bit_cnt[2:0]]
                            : !tx_word[4'hF - {1'b0, bit_cnt[2:0]}];
      end
      else
      begin
        sda_oe <= 1'b0;
      end
    end
  end

  // open drain: only ever drive low, never the clock
  assign sda_out = 1'b0;
  assign scl_out = 1'b0;
  assign scl_oe = 1'b0;

  // queue word: command, upper, lower
  assign fifo_in = {cmd_reg, hi_reg, shift};

  // write queue, pushed when the lower byte completes
  dacsp_fifo
  #(
    .WIDTH(DACSP_FIFO_WIDTH),
    .DEPTH(DACSP_FIFO_DEPTH)
  )
  u_fifo
  (
    .clock(clock),
    .sys_rst(sys_rst),
    .in_valid(scl_fall && bit_cnt == DACSP_BITS_PER_BYTE - 4'h1 && !ack_phase
              && state == DACSP_LOW),
    .in_ready(fifo_ready),
    .in_data(fifo_in),
    .out_valid(fifo_valid),
    .out_ready(wr_ready && !update_pend),
    .out_data(fifo_out)
  );

  // registered update outputs; released after the ack falls
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wr_valid <= 1'b0;
      wr_command <= 8'h00;
      upper_data_byte <= 8'h00;
      lower_data_byte <= 8'h00;
    end
    else
    begin
      wr_valid <= fifo_valid && wr_ready && !update_pend;
      if (fifo_valid && wr_ready && !update_pend)
      begin
        wr_command <= fifo_out[23:16];
        upper_data_byte <= fifo_out[15:8];
        lower_data_byte <= fifo_out[7:0];
      end
    end
  end
endmodule : dacsp_port
`default_nettype wire

// file: bench/dacsp_chk.sv
// checker: acknowledge, release and reset pulse of the slave port
// assumes it sees the pins as the port sees them; bound below
`timescale 1ns/1ps
`default_nettype none
module dacsp_chk
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic scl_in,
  input wire logic scl_oe,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic [1:0] address_select_pin,
  input wire logic soft_reset
);
  logic scl_q, sda_q; // pin levels a cycle ago
  logic quiet; // bus released, no drive
  logic [3:0] bits; // bit within byte
  logic [1:0] nbyte; // saturating byte index
  logic [7:0] sh; // shifted-in byte
  logic [7:0] fb; // first byte of frame
  wire rise = scl_in && !scl_q;
  wire ack9 = rise && bits == 4'h8; // ninth clock
  wire strt = scl_in && scl_q && sda_q && !sda_in;
  wire stp = scl_in && scl_q && !sda_q && sda_in;
  wire own = sh[7:1] == {4'h9, 1'b0, address_select_pin};
  wire adr = ack9 && nbyte == 2'h0; // address ack
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // follow bits and bytes on the wire
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      quiet <= 1'b1;
      bits <= 4'h0;
      nbyte <= 2'h0;
      sh <= 8'h00;
      fb <= 8'h00;
    end
    else
    begin
      scl_q <= scl_in;
      sda_q <= sda_in;
      if (strt)
      begin
        bits <= 4'h0;
        nbyte <= 2'h0;
        quiet <= 1'b0;
      end
      else if (stp)
        quiet <= 1'b1;
      else if (ack9)
      begin
        bits <= 4'h0;
        nbyte <= nbyte | {nbyte[0], 1'b1};
        if (nbyte == 2'h0)
        begin
          fb <= sh;
          quiet <= !sda_oe; // unmatched address
        end
      end
      else if (rise)
      begin
        bits <= bits + 4'h1;
        sh <= {sh[6:0], sda_in};
      end
    end
  end
  scl_idle_a: assert property (!scl_oe)
    else $error("clock driven");
  sda_low_a: assert property (sda_oe |-> !sda_out)
    else $error("data driven high");
  bus_quiet_a: assert property (quiet |-> !sda_oe)
    else $error("drive while released");
  sda_steady_a: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data moved in high");
  own_ack_a: assert property (adr && own |-> sda_oe)
    else $error("own address not acked");
  foreign_nak_a: assert property (adr && sda_oe |-> own || sh == 8'h8E || sh == 8'h00)
    else $error("foreign address acked");
  bcast_read_a: assert property (adr && sh == 8'h8F |-> !sda_oe)
    else $error("broadcast read acked");
  gcall_rst_a: assert property (ack9 && nbyte == 2'h1 && fb == 8'h00
    && sh == 8'h06 |-> ##[0:6] soft_reset) else $error("no reset pulse");
  rst_pulse_a: assert property (soft_reset |=> !soft_reset)
    else $error("reset pulse too long");
endmodule : dacsp_chk
bind dacsp_port dacsp_chk i_dacsp_chk
(
  .clock(clock), .sys_rst(sys_rst), .scl_in(scl_in), .scl_oe(scl_oe),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .address_select_pin(address_select_pin), .soft_reset(soft_reset)
);
`default_nettype wire

// file: bench/dacsp_bm.sv
// bus master model: bus clock, start, stop and bytes
// assumes open drain outside; driving 1 releases a line
`timescale 1ns/1ps
`default_nettype none
module dacsp_bm
(
  input wire logic clock,
  input wire logic sda_line,
  output var logic scl_drv,
  output var logic sda_drv
);
  // lines released at power up
  initial
  begin
    scl_drv = 1'b1;
    sda_drv = 1'b1;
  end
  // one 80 ns clock: low 5 cycles, high 3
  task bit_io(input logic b, output logic s);
    scl_drv <= 1'b0;
    repeat (2) @(posedge clock);
    sda_drv <= b;
    repeat (3) @(posedge clock);
    scl_drv <= 1'b1;
    repeat (2) @(posedge clock);
    s = sda_line;
    @(posedge clock);
  endtask : bit_io
  // start, or repeated start when rep
  task start(input logic rep);
    if (rep)
    begin
      scl_drv <= 1'b0;
      repeat (2) @(posedge clock);
      sda_drv <= 1'b1;
      repeat (3) @(posedge clock);
      scl_drv <= 1'b1;
      repeat (3) @(posedge clock);
    end
    sda_drv <= 1'b0;
    repeat (3) @(posedge clock);
  endtask : start
  // stop, then bus rests high
  task stop;
    scl_drv <= 1'b0;
    repeat (2) @(posedge clock);
    sda_drv <= 1'b0;
    repeat (3) @(posedge clock);
    scl_drv <= 1'b1;
    repeat (3) @(posedge clock);
    sda_drv <= 1'b1;
    repeat (4) @(posedge clock);
  endtask : stop
  // eight bits out msb first, then the ninth clock
  task wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], s);
    bit_io(1'b1, s);
    ack = !s;
  endtask : wbyte
  // eight bits in, master answers on the ninth
  task rbyte(input logic ack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, b[i]);
    bit_io(!ack, s);
  endtask : rbyte
endmodule : dacsp_bm
`default_nettype wire

// file: bench/dacsp_port_tb.sv
// self-checking bench of the two-wire slave port
// assumes dacsp_bm as master and dacsp_chk bound to the port
`timescale 1ns/1ps
`default_nettype none
module dacsp_port_tb;
  logic clock, sys_rst; // clock and reset
  logic scl_oe, sda_oe, scl_drv, sda_drv; // pin drives
  logic [1:0] address_select_pin; // strap code
  logic wr_ready, soft_reset, wr_valid; // update handshake
  logic [15:0] rd_data; // register read back
  logic [7:0] wr_command, upper_data_byte, lower_data_byte, rd_command;
  logic [23:0] last_wr; // last update taken
  logic scl_out, sda_out; // levels driven when enabled
  logic [15:0] regs [256]; // register file behind the port
  int failures = 0;
  int n_compared = 0;
  int n_wr = 0; // updates taken
  int n_rst = 0; // reset pulses
  wire scl_line = scl_drv && !(scl_oe === 1'b1 && scl_out !== 1'b1);
  wire sda_line = sda_drv && !(sda_oe === 1'b1 && sda_out !== 1'b1);
  dacsp_port i_dacsp_port
  (
    .clock(clock), .sys_rst(sys_rst), .scl_in(scl_line), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .address_select_pin(address_select_pin),
    .soft_reset(soft_reset), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_command(wr_command), .upper_data_byte(upper_data_byte),
    .lower_data_byte(lower_data_byte), .rd_command(rd_command), .rd_data(rd_data)
  );
  dacsp_bm i_dacsp_bm (.clock(clock), .sda_line(sda_line), .scl_drv(scl_drv), .sda_drv(sda_drv));
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // record updates taken and reset pulses
  always @(posedge clock)
  begin
    if (wr_valid === 1'b1 && wr_ready === 1'b1)
    begin
      n_wr++;
      last_wr <= {wr_command, upper_data_byte, lower_data_byte};
      regs[wr_command] <= {upper_data_byte, lower_data_byte};
    end
    rd_data <= regs[rd_command];
    if (soft_reset === 1'b1)
      n_rst++;
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task conclude;
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  // write a byte and compare the ninth clock answer
  task w(input logic [7:0] b, input logic e);
    logic a;
    i_dacsp_bm.wbyte(b, a);
    check(a, e);
  endtask : w
  // read a byte and compare it
  task r(input logic ack, input logic [7:0] e);
    logic [7:0] d;
    i_dacsp_bm.rbyte(ack, d);
    check(d, e);
  endtask : r
  // whole update frame, every byte answered alike
  task upd(input logic [6:0] ad, input logic [7:0] c, input logic [7:0] u,
    input logic [7:0] l, input logic e);
    i_dacsp_bm.start(1'b0);
    w({ad, 1'b0}, e);
    w(c, e);
    w(u, e);
    w(l, e);
    i_dacsp_bm.stop();
    repeat (4) @(posedge clock);
  endtask : upd
  // every strap and broadcast, wrong and 10-bit addresses
  task t_write;
    int c0;
    for (int s = 0; s < 5; s++)
    begin
      address_select_pin <= 2'(s);
      c0 = n_wr;
      upd(s < 4 ? {5'h12, 2'(s)} : 7'h47, 8'h21, 8'(s), 8'h5C, 1'b1);
      upd({5'h12, 2'(s + 1)}, 8'h25, 8'h00, 8'h00, 1'b0);
      check(n_wr - c0, 1);
      check(last_wr, {8'h21, 8'(s), 8'h5C});
    end
    i_dacsp_bm.start(1'b0);
    w(8'h8F, 1'b0);
    i_dacsp_bm.start(1'b1);
    w(8'hF0, 1'b0);
    w(8'h00, 1'b0);
    i_dacsp_bm.stop();
    $display("write test done");
  endtask : t_write
  // command then repeated start read, then a bare read
  task t_read;
    address_select_pin <= 2'h3;
    upd(7'h4B, 8'hD1, 8'hB3, 8'h7C, 1'b1);
    upd(7'h4B, 8'h21, 8'h4E, 8'h81, 1'b1);
    i_dacsp_bm.start(1'b0);
    w(8'h96, 1'b1);
    w(8'hD1, 1'b1);
    i_dacsp_bm.start(1'b1);
    w(8'h97, 1'b1);
    r(1'b1, 8'hB3);
    check(rd_command, 8'hD1);
    r(1'b0, 8'h7C);
    i_dacsp_bm.stop();
    repeat (2) @(posedge clock);
    check(rd_command, 8'h21);
    i_dacsp_bm.start(1'b0);
    w(8'h97, 1'b1);
    r(1'b1, 8'h4E);
    r(1'b0, 8'h81);
    i_dacsp_bm.stop();
    $display("read test done");
  endtask : t_read
  // general call reset
  task t_gcall;
    int c0;
    c0 = n_rst;
    i_dacsp_bm.start(1'b0);
    w(8'h00, 1'b1);
    w(8'h06, 1'b1);
    i_dacsp_bm.stop();
    check(n_rst - c0, 1);
    $display("general call test done");
  endtask : t_gcall
  // fill the buffer with the sink stalled, then drain
  task t_fifo;
    int c0;
    wr_ready <= 1'b0;
    i_dacsp_bm.start(1'b0);
    w(8'h96, 1'b1);
    w(8'h26, 1'b1);
    for (int i = 0; i < 9; i++)
    begin
      w(8'(i), 1'b1);
      w(~8'(i), i < 8);
    end
    i_dacsp_bm.stop();
    c0 = n_wr;
    wr_ready <= 1'b1;
    repeat (40) @(posedge clock);
    check(n_wr - c0, 8);
    check(last_wr, 24'h2607F8);
    $display("buffer test done");
  endtask : t_fifo
  initial
  begin
    sys_rst = 1'b1;
    address_select_pin = 2'h0;
    wr_ready = 1'b1;
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clock);
    t_write();
    t_read();
    t_gcall();
    t_fifo();
    conclude();
  end
  // cut a hang short
  initial
  begin
    repeat (30000) @(posedge clock);
    failures++;
    conclude();
  end
endmodule : dacsp_port_tb
`default_nettype wire
